// ---- tss_cfg.svh ----
// Function
// - data interrupt on new unread output data
// - status interrupt on new status; both allowed
// - direction enable; else all counts forward
// - mode byte 01H enters version mode
// - version mode writes status, output untouched
// - version code 00H to FEH, never FFH
// - in version mode next byte selects mode
// - open phase lasts exactly minimum sample time
// - close ends on transition or maximum time
// - close end starts next interval, no gap
// - free accumulators, differences per interval
// - pulse accumulator is 16-bit counter
// - time accumulator 16-bit plus 8-bit overflow
// - time base runs at 1 MHz
// - math in open phase, pulse captures accumulators
// - speed is constant times pulses over time
// - division one extra bit then rounded
// - subtract and multiply at full precision
// - invalid mode loads FFH status, wait reset
// - count source select field, eight codes
// - speed is signed 16-bit, zero is 0000H
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH
`define TSS_MODE_VERSION 8'h01
`define TSS_MODE_SPEED 8'h02
`define TSS_MODE_LAST 8'h04
`define TSS_STAT_INVALID 8'hff
`define TSS_VERSION_MAX 8'hfe
`define TSS_CLK_HZ 100_000_000
`define TSS_TB_HZ 1_000_000
`define TSS_TB_DIV (`TSS_CLK_HZ / `TSS_TB_HZ)
`define TSS_SEL_SRC_LO 0
`define TSS_SEL_SRC_HI 2
`define TSS_SEL_DIR 3
`define TSS_SEL_STAT_IRQ 4
`define TSS_SEL_DATA_IRQ 5
`define TSS_SPEED_MAX 16'h7fff
`define TSS_SPEED_ZERO 16'h0000
`define TSS_SAMPLE_SHIFT 8
`endif

// ---- tss_pkg.sv ----
package tss_pkg;
    typedef enum logic [2:0] {
        TSS_SRC_TEST, TSS_SRC_B_X1, TSS_SRC_A_X1, TSS_SRC_AB_X4,
        TSS_SRC_A_X2, TSS_SRC_B_X2, TSS_SRC_OFF, TSS_SRC_OTHER
    } tss_src_e;
endpackage

// ---- tss_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; output changes once stages two and three agree
module tss_sync
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic next_level;

    // stage 0 feeds only stage 1
    always_comb
    begin
        next_level = level;
        if (stage[1] == stage[2])
        begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stage <= 3'h0;
            level <= 1'b0;
        end
        else
        begin
            stage <= {stage[1:0], pin};
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

// ---- tss_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"
// restoring divider: one quotient bit per clock, one extra bit for rounding
module tss_divider
#(
    parameter int NUM_W = 40,
    parameter int DEN_W = 24
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic start,
    input wire logic [NUM_W-1:0] numer,
    input wire logic [DEN_W-1:0] denom,
    output logic busy,
    output logic done,
    output logic [NUM_W:0] quot
);
    localparam int CW = $clog2(NUM_W + 2);
    logic [NUM_W:0] num_sh;
    logic [DEN_W:0] rem;
    logic [DEN_W-1:0] den;
    logic [CW-1:0] cnt;
    logic [NUM_W:0] next_num_sh;
    logic [DEN_W:0] next_rem;
    logic [DEN_W-1:0] next_den;
    logic [CW-1:0] next_cnt;
    logic [NUM_W:0] next_quot;
    logic next_busy;
    logic next_done;
    logic [DEN_W+1:0] trial;

    initial
    begin
        if (NUM_W < 2 || DEN_W < 2)
        begin
            $error("tss_divider widths too small");
        end
    end

    // numerator is shifted left once so the last quotient bit is a half
    always_comb
    begin
        next_num_sh = num_sh;
        next_rem = rem;
        next_den = den;
        next_cnt = cnt;
        next_quot = quot;
        next_busy = busy;
        next_done = 1'b0;
        trial = '0;
        if (start && !busy)
        begin
            next_num_sh = {numer, 1'b0};
            next_rem = '0;
            next_den = denom;
            next_cnt = CW'(NUM_W + 1);
            next_quot = '0;
            next_busy = 1'b1;
        end
        else if (busy)
        begin
            trial = {rem, num_sh[NUM_W]} - {2'b00, den};
            if (!trial[DEN_W+1])
            begin
                next_rem = trial[DEN_W:0];
                next_quot = {quot[NUM_W-1:0], 1'b1};
            end
            else
            begin
                next_rem = {rem[DEN_W-1:0], num_sh[NUM_W]};
                next_quot = {quot[NUM_W-1:0], 1'b0};
            end
            next_num_sh = {num_sh[NUM_W-1:0], 1'b0};
            next_cnt = cnt - CW'(1);
            if (cnt == CW'(1))
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            num_sh <= '0;
            rem <= '0;
            den <= '0;
            cnt <= '0;
            quot <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            num_sh <= next_num_sh;
            rem <= next_rem;
            den <= next_den;
            cnt <= next_cnt;
            quot <= next_quot;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ---- tss_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"
// one tach channel: mode handling, sample interval, accumulators, speed
module tss_channel
    import tss_pkg::*;
#(
    parameter logic [7:0] VERSION_CODE = 8'h10, // arbitrary release code
    parameter int TB_DIV = `TSS_TB_DIV
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic tach_a,
    input wire logic tach_b,
    input wire logic test_reference_source,
    input wire logic other_channel_source,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    input wire logic [7:0] input_select_byte,
    input wire logic [23:0] calibration_constant,
    input wire logic [15:0] min_sample_time,
    input wire logic [15:0] max_sample_time,
    input wire logic out_read,
    input wire logic stat_read,
    output logic [15:0] channel_output_buffer,
    output logic out_full,
    output logic [7:0] channel_status_buffer,
    output logic stat_full,
    output logic [7:0] current_mode,
    output logic count_source_pulse,
    output logic irq
);
    typedef enum logic [1:0] {TSS_WAIT_MODE, TSS_VERSION, TSS_SPEED,
                              TSS_HALT} tss_mode_e;
    typedef enum logic [1:0] {TSS_FIRST, TSS_OPEN, TSS_CLOSE} tss_phase_e;

    initial
    begin
        if (TB_DIV < 1)
        begin
            $error("tss_channel time base divider must be positive");
        end
    end

    logic a_s, b_s, test_s, other_s;
    tss_sync u_sa (.clk_sys(clk_sys), .srst(srst), .pin(tach_a),
                   .level(a_s));
    tss_sync u_sb (.clk_sys(clk_sys), .srst(srst), .pin(tach_b),
                   .level(b_s));
    tss_sync u_st (.clk_sys(clk_sys), .srst(srst),
                   .pin(test_reference_source), .level(test_s));
    tss_sync u_so (.clk_sys(clk_sys), .srst(srst),
                   .pin(other_channel_source), .level(other_s));

    // ---------------- edge detection and count source
    logic a_d, b_d, test_d, other_d;
    logic a_e, b_e, a_r, b_r, test_r, other_r;
    logic cnt_ev, dir_rev;
    tss_src_e src;
    assign src = tss_src_e'(input_select_byte[`TSS_SEL_SRC_HI:`TSS_SEL_SRC_LO]);
    assign a_e = a_s ^ a_d;
    assign b_e = b_s ^ b_d;
    assign a_r = a_s & ~a_d;
    assign b_r = b_s & ~b_d;
    assign test_r = test_s & ~test_d;
    assign other_r = other_s & ~other_d;

    // select which edges count
    always_comb
    begin
        case (src)
            TSS_SRC_TEST: cnt_ev = test_r;
            TSS_SRC_B_X1: cnt_ev = b_r;
            TSS_SRC_A_X1: cnt_ev = a_r;
            TSS_SRC_AB_X4: cnt_ev = a_e | b_e;
            TSS_SRC_A_X2: cnt_ev = a_e;
            TSS_SRC_B_X2: cnt_ev = b_e;
            TSS_SRC_OFF: cnt_ev = 1'b0;
            default: cnt_ev = other_r;
        endcase
    end
    assign count_source_pulse = cnt_ev;

    // quadrature: a rising edge of a while b high means reverse
    logic dir_en;
    assign dir_en = input_select_byte[`TSS_SEL_DIR];
    assign dir_rev = dir_en & ((a_r & b_s) | (a_e & b_e));

    // ---------------- accumulators
    logic [15:0] pulse_acc, next_pulse_acc;
    logic [15:0] time_acc, next_time_acc;
    logic [7:0] time_ovf, next_time_ovf;
    localparam int TBW = $clog2(TB_DIV + 1);
    logic [TBW-1:0] tb_cnt, next_tb_cnt;
    logic tb_tick;
    assign tb_tick = (tb_cnt == '0);

    // free-running counters, never cleared except by reset
    always_comb
    begin
        next_tb_cnt = tb_tick ? TBW'(TB_DIV - 1) : tb_cnt - TBW'(1);
        next_pulse_acc = pulse_acc + 16'(cnt_ev);
        next_time_acc = time_acc + 16'(tb_tick);
        next_time_ovf = time_ovf;
        if (tb_tick && time_acc == 16'hffff)
        begin
            next_time_ovf = time_ovf + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            a_d <= 1'b0;
            b_d <= 1'b0;
            test_d <= 1'b0;
            other_d <= 1'b0;
            pulse_acc <= 16'h0000;
            time_acc <= 16'h0000;
            time_ovf <= 8'h00;
            tb_cnt <= '0;
        end
        else
        begin
            a_d <= a_s;
            b_d <= b_s;
            test_d <= test_s;
            other_d <= other_s;
            pulse_acc <= next_pulse_acc;
            time_acc <= next_time_acc;
            time_ovf <= next_time_ovf;
            tb_cnt <= next_tb_cnt;
        end
    end

    // ---------------- mode and sample interval control
    tss_mode_e mode, next_mode;
    tss_phase_e phase, next_phase;
    logic [23:0] phase_t, next_phase_t; // time-base ticks since start
    logic [15:0] cap_p, next_cap_p;
    logic [23:0] cap_t, next_cap_t;
    logic [15:0] np, next_np;
    logic [23:0] nt, next_nt;
    logic rev_seen, next_rev_seen;
    logic rev_int, next_rev_int;
    logic div_start, next_div_start;
    logic [23:0] min_ticks, max_ticks;
    logic [23:0] now_t;
    logic sample_end;
    assign min_ticks = 24'(min_sample_time) << `TSS_SAMPLE_SHIFT; // 256 us
    assign max_ticks = 24'(max_sample_time) << `TSS_SAMPLE_SHIFT;
    assign now_t = {time_ovf, time_acc};
    assign in_ready = (mode == TSS_WAIT_MODE) || (mode == TSS_VERSION);
    assign current_mode = (mode == TSS_VERSION) ? `TSS_MODE_VERSION :
                          (mode == TSS_SPEED) ? `TSS_MODE_SPEED : 8'h00;

    // interval ends on a pulse after the open phase or at the max time
    assign sample_end = (phase == TSS_CLOSE) &&
                        (cnt_ev || (phase_t >= max_ticks));

    always_comb
    begin
        next_mode = mode;
        next_phase = phase;
        next_phase_t = phase_t + 24'(tb_tick);
        next_cap_p = cap_p;
        next_cap_t = cap_t;
        next_np = np;
        next_nt = nt;
        next_rev_seen = rev_seen | dir_rev;
        next_rev_int = rev_int;
        next_div_start = 1'b0;
        if (in_valid && in_ready)
        begin
            if (in_byte == `TSS_MODE_VERSION)
            begin
                next_mode = TSS_VERSION;
            end
            else if (in_byte == `TSS_MODE_SPEED)
            begin
                next_mode = TSS_SPEED;
                next_phase = TSS_FIRST;
            end
            else
            begin
                next_mode = TSS_HALT;
            end
        end
        if (mode == TSS_SPEED)
        begin
            case (phase)
                TSS_FIRST:
                begin
                    if (cnt_ev)
                    begin
                        next_phase = TSS_OPEN;
                        next_phase_t = 24'h00_0000;
                        next_cap_p = pulse_acc;
                        next_cap_t = now_t;
                        next_rev_seen = 1'b0;
                    end
                end
                TSS_OPEN:
                begin
                    if (phase_t >= min_ticks)
                    begin
                        next_phase = TSS_CLOSE;
                    end
                end
                default:
                begin
                    if (sample_end)
                    begin
                        next_phase = TSS_OPEN;
                        next_phase_t = 24'h00_0000;
                        next_cap_p = pulse_acc;
                        next_cap_t = now_t;
                        next_np = pulse_acc - cap_p;
                        next_nt = now_t - cap_t;
                        next_rev_int = rev_seen | dir_rev;
                        next_rev_seen = 1'b0;
                        next_div_start = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode <= TSS_WAIT_MODE;
            phase <= TSS_FIRST;
            phase_t <= 24'h00_0000;
            cap_p <= 16'h0000;
            cap_t <= 24'h00_0000;
            np <= 16'h0000;
            nt <= 24'h00_0000;
            rev_seen <= 1'b0;
            rev_int <= 1'b0;
            div_start <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            phase <= next_phase;
            phase_t <= next_phase_t;
            cap_p <= next_cap_p;
            cap_t <= next_cap_t;
            np <= next_np;
            nt <= next_nt;
            rev_seen <= next_rev_seen;
            rev_int <= next_rev_int;
            div_start <= next_div_start;
        end
    end

    // ---------------- speed arithmetic, run while the open phase lasts
    logic [39:0] product;
    logic [40:0] quot;
    logic div_done;
    logic [40:0] rounded;
    logic [15:0] speed;
    assign product = 40'(np) * 40'(calibration_constant);

    tss_divider #(.NUM_W(40), .DEN_W(24)) u_div
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(div_start),
        .numer(product),
        .denom((nt == 24'h00_0000) ? 24'h00_0001 : nt),
        .busy(),
        .done(div_done),
        .quot(quot)
    );

    // round the half bit away, saturate magnitude to fifteen bits
    always_comb
    begin
        rounded = (quot + 41'd1) >> 1;
        if (rev_int)
        begin
            speed = `TSS_SPEED_ZERO;
        end
        else if (rounded > 41'(`TSS_SPEED_MAX))
        begin
            speed = `TSS_SPEED_MAX;
        end
        else
        begin
            speed = rounded[15:0];
        end
    end

    // ---------------- output and status buffers with full flags
    logic [15:0] next_obuf;
    logic [7:0] next_sbuf;
    logic next_ofull, next_sfull;
    logic new_data, new_stat;
    logic [7:0] ver;
    assign ver = (VERSION_CODE > `TSS_VERSION_MAX) ? `TSS_VERSION_MAX
                                                   : VERSION_CODE;
    assign new_data = (mode == TSS_SPEED) && div_done;
    assign new_stat = (mode == TSS_VERSION) ||
                      ((mode == TSS_HALT) &&
                       channel_status_buffer != `TSS_STAT_INVALID);

    // a new posting wins over a read in the same cycle
    always_comb
    begin
        next_obuf = channel_output_buffer;
        next_sbuf = channel_status_buffer;
        next_ofull = out_full & ~out_read;
        next_sfull = stat_full & ~stat_read;
        if (new_data)
        begin
            next_obuf = speed;
            next_ofull = 1'b1;
        end
        if (mode == TSS_VERSION)
        begin
            next_sbuf = ver;
            if (channel_status_buffer != ver)
            begin
                next_sfull = 1'b1;
            end
        end
        else if (mode == TSS_HALT)
        begin
            next_sbuf = `TSS_STAT_INVALID;
            if (new_stat)
            begin
                next_sfull = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            channel_output_buffer <= 16'h0000;
            channel_status_buffer <= 8'h00;
            out_full <= 1'b0;
            stat_full <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            channel_output_buffer <= next_obuf;
            channel_status_buffer <= next_sbuf;
            out_full <= next_ofull;
            stat_full <= next_sfull;
            irq <= (input_select_byte[`TSS_SEL_DATA_IRQ] & next_ofull)
                 | (input_select_byte[`TSS_SEL_STAT_IRQ] & next_sfull);
        end
    end
endmodule
`default_nettype wire

// ---- tss_channel_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checks for one tach channel
module tss_channel_checker
#(
    parameter logic [7:0] VERSION_CODE = 8'h10
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_ready,
    input wire logic [7:0] input_select_byte,
    input wire logic [15:0] channel_output_buffer,
    input wire logic out_full,
    input wire logic [7:0] channel_status_buffer,
    input wire logic stat_full,
    input wire logic [7:0] current_mode,
    input wire logic count_source_pulse,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic take;
    logic want;
    // byte taken, and the request level that the irq output must follow
    assign take = in_valid && in_ready;
    assign want = (input_select_byte[5] && out_full)
        || (input_select_byte[4] && stat_full);

    // irq is registered, so two settled cycles are allowed before judging
    property p_irq_on;
        want [*2] |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("irq low while a selected buffer is full");
    property p_irq_off;
        !want [*2] |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq high with no selected source");
    // a mode byte 01 in wait mode must enter version mode; a halted channel (status ff) is not checked
    property p_enter_ver;
        take && in_byte == 8'h01 && current_mode == 8'h00
            && channel_status_buffer != 8'hff
            |=> current_mode == 8'h01 ##1 stat_full;
    endproperty
    a_enter_ver: assert property (p_enter_ver)
        else $error("version mode not entered");
    property p_ver_stat;
        current_mode == 8'h01 [*2] |-> channel_status_buffer == VERSION_CODE
            && channel_status_buffer != 8'hff;
    endproperty
    a_ver_stat: assert property (p_ver_stat)
        else $error("status does not hold the version code");
    property p_out_kept;
        current_mode == 8'h01 |=> $stable(channel_output_buffer);
    endproperty
    a_out_kept: assert property (p_out_kept)
        else $error("output buffer changed in version mode");
    property p_to_speed;
        take && current_mode == 8'h01 && in_byte == 8'h02
            |=> current_mode == 8'h02;
    endproperty
    a_to_speed: assert property (p_to_speed)
        else $error("mode byte in version mode not obeyed");
    property p_invalid;
        take && in_byte != 8'h01 && in_byte != 8'h02
            |=> current_mode == 8'h00
            ##1 channel_status_buffer == 8'hff && stat_full;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("invalid mode byte not flagged");
    property p_speed_sign;
        $rose(out_full) |-> !channel_output_buffer[15];
    endproperty
    a_speed_sign: assert property (p_speed_sign)
        else $error("forward speed posted with sign set");
    // the pin path is a few flops deep, so wait it out first
    property p_src_off;
        input_select_byte[2:0] == 3'b110 [*5] |-> !count_source_pulse;
    endproperty
    a_src_off: assert property (p_src_off)
        else $error("count pulse with source switched off");
endmodule

bind tss_channel tss_channel_checker #(.VERSION_CODE(VERSION_CODE)) u_chk (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(in_valid),
    .in_byte(in_byte),
    .in_ready(in_ready),
    .input_select_byte(input_select_byte),
    .channel_output_buffer(channel_output_buffer),
    .out_full(out_full),
    .channel_status_buffer(channel_status_buffer),
    .stat_full(stat_full),
    .current_mode(current_mode),
    .count_source_pulse(count_source_pulse),
    .irq(irq)
);
`default_nettype wire

// ---- tss_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// bus master side: byte strobes and buffer reads, all on the falling edge
module tss_host_model
(
    input wire logic clk_sys,
    input wire logic auto_read,
    input wire logic out_full,
    input wire logic stat_full,
    output logic out_read,
    output logic stat_read,
    output logic in_valid,
    output logic [7:0] in_byte
);
    initial
    begin
        out_read = 1'b0;
        stat_read = 1'b0;
        in_valid = 1'b0;
        in_byte = 8'h00;
    end
    // drain both buffers so stale status never waits to be misread
    always @(negedge clk_sys)
    begin
        out_read <= auto_read && out_full && !out_read;
        stat_read <= auto_read && stat_full && !stat_read;
    end
    // one byte per strobe; settings are driven straight on their own ports
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        in_valid = 1'b1;
        in_byte = b;
        @(negedge clk_sys);
        in_valid = 1'b0;
        in_byte = ~b; // released bus must not show the old byte
    endtask
endmodule
`default_nettype wire

// ---- tb_tss_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for one tach channel
module tb_tss_channel;
    localparam logic [7:0] VER = 8'h24; // arbitrary release code
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic tach_a = 1'b0;
    logic tach_b = 1'b0;
    logic auto_read = 1'b1;
    logic [7:0] input_select_byte = 8'h06;
    logic [23:0] calibration_constant = 24'h00_0000;
    logic test_src = 1'b0;
    logic other_src = 1'b0;
    logic [15:0] min_time = 16'h0001;
    logic [15:0] max_time = 16'h0004;
    logic count_pulse;
    int n_pulse = 0;
    logic in_valid, in_ready, out_read, stat_read, out_full, stat_full, irq;
    logic [7:0] in_byte, channel_status_buffer, current_mode;
    logic [15:0] channel_output_buffer;
    logic [15:0] exp_out[$];
    logic [7:0] exp_stat[$];
    int n_fail = 0;
    int n_compared = 0;

    always #5 clk_sys = ~clk_sys;

    // short time base: one tick every two clocks, sample unit 512 clocks
    tss_channel #(.VERSION_CODE(VER), .TB_DIV(2)) DUT (
        .clk_sys(clk_sys), .srst(srst), .tach_a(tach_a), .tach_b(tach_b),
        .test_reference_source(test_src), .other_channel_source(other_src),
        .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
        .input_select_byte(input_select_byte),
        .calibration_constant(calibration_constant),
        .min_sample_time(min_time), .max_sample_time(max_time),
        .out_read(out_read), .stat_read(stat_read),
        .channel_output_buffer(channel_output_buffer), .out_full(out_full),
        .channel_status_buffer(channel_status_buffer), .stat_full(stat_full),
        .current_mode(current_mode), .count_source_pulse(count_pulse),
        .irq(irq));

    tss_host_model host (
        .clk_sys(clk_sys), .auto_read(auto_read), .out_full(out_full),
        .stat_full(stat_full), .out_read(out_read), .stat_read(stat_read),
        .in_valid(in_valid), .in_byte(in_byte));

    task automatic check8(input string what, input logic [7:0] e,
        input logic [7:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic check16(input string what, input logic [15:0] e,
        input logic [15:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // each host read takes the oldest note of what should be there
    always @(posedge clk_sys)
    begin
        if (out_read && out_full && exp_out.size() > 0)
            check16("speed", exp_out.pop_front(), channel_output_buffer);
        if (stat_read && stat_full && exp_stat.size() > 0)
            check8("status", exp_stat.pop_front(), channel_status_buffer);
        if (count_pulse)
            n_pulse++;
    end

    task automatic do_reset();
        srst = 1'b1;
        input_select_byte = 8'h06;
        repeat (4) @(negedge clk_sys);
        srst = 1'b0;
    endtask

    // 200-clock pulses: one pulse per 100 ticks, so the speed is kc/100
    task automatic run_speed(input logic [23:0] kc, input logic [15:0] s,
        input logic [7:0] sel, input logic [15:0] tmin);
        calibration_constant = kc;
        min_time = tmin;
        input_select_byte = sel; // single phase, direction off
        auto_read = 1'b0;
        n_pulse = 0;
        host.send(8'h02);
        check8("mode", 8'h02, current_mode);
        repeat (3) exp_out.push_back(s);
        fork
            repeat (60)
            begin
                tach_a = ~tach_a;
                test_src = ~test_src;
                other_src = ~other_src;
                tach_b = 1'($urandom);
                repeat (100) @(negedge clk_sys);
            end
            begin
                for (int i = 0; i < 3000 && !out_full; i++)
                    @(negedge clk_sys);
                repeat (3) @(negedge clk_sys);
                check8("irq", 8'h01, {7'h00, irq});
                auto_read = 1'b1;
            end
        join
        check8("pending", 8'h00, 8'(exp_out.size()));
        check8("pulses", 8'h1e, 8'(n_pulse));
        // pulses stop: one interval ends at the max time, the next counts none
        repeat (2000) @(negedge clk_sys);
        exp_out.push_back(16'h0000);
        repeat (2100) @(negedge clk_sys);
        check8("idle", 8'h00, 8'(exp_out.size()));
    endtask

    initial
    begin
        logic [7:0] code;
        void'($urandom(32'hdd50d9b8));
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        // version mode with status interrupt, then on into speed mode
        input_select_byte = 8'h16;
        auto_read = 1'b0;
        exp_stat.push_back(VER);
        host.send(8'h01);
        check8("mode", 8'h01, current_mode);
        repeat (2) @(negedge clk_sys);
        check8("irq", 8'h01, {7'h00, irq});
        auto_read = 1'b1;
        run_speed(24'h00_2710, 16'h0064, 8'h22, 16'h0001);
        // fresh start; the full-scale constant drives the result past range
        do_reset();
        run_speed(24'hff_ffff, 16'h7fff, ($urandom % 2) ? 8'h27 : 8'h20,
            16'h0002);
        // unknown mode bytes halt the channel until the next reset
        for (int i = 0; i < 3; i++)
        begin
            do_reset();
            code = 8'h03 + 8'($urandom % 253);
            if (i == 1)
            begin
                exp_stat.push_back(VER);
                host.send(8'h01);
            end
            exp_stat.push_back(8'hff);
            host.send(code);
            host.send(8'h01);
            repeat (4) @(negedge clk_sys);
            check8("mode", 8'h00, current_mode);
            check8("pending", 8'(exp_stat.size()), 8'h00);
        end
        print_verdict();
    end

    // the whole run needs about 20300 clocks
    initial
    begin
        #400_000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
